// [bench/fsu_remote_dev.sv]
// fsu_remote_dev: far-side device feeding bytes and an external clock
`timescale 1ns/1ps
`default_nettype none
module fsu_remote_dev
  import fsu_pkg::*;
(
  // clock
  input wire logic clk,
  // receive stream
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic rxParityFault,
  output logic rxFramingFault,
  // external serial clock
  output logic extClock
);
  logic [7:0] noise = 8'h5a; // churns while idle
  logic [9:0] hold = 10'h000; // faults and byte of a push
  // idle lines do not hold the last byte; noise steps by 8'h35 each cycle
  always @(posedge clk) noise <= noise + 8'h35;
  assign rxByte = rxValid ? hold[7:0] : noise;
  assign rxParityFault = rxValid ? hold[8] : noise[0];
  assign rxFramingFault = rxValid ? hold[9] : noise[1];
  initial rxValid = 1'b0;
  initial extClock = 1'b0;
  // one byte for one cycle
  task automatic push(input logic par, input logic frm, input logic [7:0] b);
    @(posedge clk);
    rxValid <= 1'b1;
    hold <= {frm, par, b};
    @(posedge clk);
    rxValid <= 1'b0;
  endtask
  // frame of n periods of 800 ns, still outside frames
  task automatic runClock(input int n);
    @(posedge clk);
    #37;
    repeat (n) begin
      extClock = 1'b1;
      #400;
      extClock = 1'b0;
      #400;
    end
  endtask
endmodule // fsu_remote_dev
`default_nettype wire

// [bench/fsu_serial_unit_checker.sv]
// fsu_serial_unit_checker: port assertions for the serial unit
`timescale 1ns/1ps
`default_nettype none
module fsu_serial_unit_checker
  import fsu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pin and tick
  input wire logic clockPinIn,
  input wire logic clockPinOut,
  input wire logic clockPinOe,
  input wire logic sampleTick
);
  // ----------------------------------------
  // shadow of the clock configuration
  // ----------------------------------------
  logic [4:0] ctlSh; // last control write
  logic syncSh; // last mode bit
  logic [3:0] age; // cycles since any write
  logic done; // write accepted
  logic settled; // pin steering has settled
  logic expOe; // expected pin enable
  assign done = write && !waitrequest;
  assign settled = age > 4'h6;
  assign expOe = ctlSh[1] ? 1'b0 : ((syncSh || ctlSh[0]) ? 1'b1 : ctlSh[3]);
  // follow accepted writes
  always_ff @(posedge clk) begin
    if (reset) begin
      ctlSh <= 5'h00;
      syncSh <= 1'b0;
      age <= 4'h0;
    end else begin
      if (done && address == ADDR_CONTROL) ctlSh <= writedata[4:0];
      if (done && address == ADDR_MODE) syncSh <= writedata[MODE_SYNC];
      if (done) age <= 4'h0;
      else if (age != 4'hf) age <= age + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered");
  a_bus_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_ctl_reserved: assert property (read && !waitrequest && address == ADDR_CONTROL |-> !readdata[2])
    else $error("reserved control bit set");
  a_status_width: assert property (read && !waitrequest && address == ADDR_STATUS
    |-> readdata[31:16] == 16'h0000)
    else $error("status wider than 16 bits");
  a_unmapped_zero: assert property (read && !waitrequest && address[3] |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_pin_enable: assert property (settled |-> clockPinOe == expOe)
    else $error("clock pin enable wrong");
  a_pin_level: assert property (settled && clockPinOe && !syncSh && ctlSh[1:0] == 2'h0
    |-> clockPinOut == ctlSh[4])
    else $error("clock pin level wrong");
  a_ext_tick: assert property (settled && ctlSh[1] && $rose(clockPinIn) |-> ##[1:6] sampleTick)
    else $error("external edge gave no tick");
  a_pin_clock: assert property (settled && clockPinOe && !ctlSh[1]
    && (syncSh || ctlSh[0]) && sampleTick |=> clockPinOut)
    else $error("clock pin not following internal clock");
  c_ext_tick: cover property (settled && ctlSh[1] && sampleTick);
  c_level: cover property (settled && clockPinOe && ctlSh[4]);
  c_status: cover property (read && !waitrequest && address == ADDR_STATUS);
endmodule // fsu_serial_unit_checker
bind fsu_serial_unit fsu_serial_unit_checker i_fsu_serial_unit_checker (.clk(clk),
  .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .clockPinIn(clockPinIn),
  .clockPinOut(clockPinOut), .clockPinOe(clockPinOe), .sampleTick(sampleTick));
`default_nettype wire

// [bench/tb.sv]
// tb: self-checking bench for the fifo serial unit
`timescale 1ns/1ps
`default_nettype none
module tb
  import fsu_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, rxValid, rxPar, rxFrm, extClock, pinOut, pinOe, tick, irq;
  logic [7:0] rxByte;
  logic clockPinIn; // wire level from both drivers
  int checks = 0;
  int failCount = 0;
  int ticks = 0;
  int t0;
  assign clockPinIn = pinOe ? pinOut : extClock;
  initial begin
    forever #50 clk = ~clk;
  end
  fsu_serial_unit i_fsu_serial_unit (.clk(clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxValid(rxValid), .rxByte(rxByte), .rxParityFault(rxPar),
    .rxFramingFault(rxFrm), .clockPinIn(clockPinIn), .clockPinOut(pinOut),
    .clockPinOe(pinOe), .sampleTick(tick), .irq(irq));
  fsu_remote_dev i_fsu_remote_dev (.clk(clk), .rxValid(rxValid), .rxByte(rxByte),
    .rxParityFault(rxPar), .rxFramingFault(rxFrm), .extClock(extClock));
  // count sample ticks
  always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
  // clock-select cases: mode, control, pin enable, level checked, level
  typedef struct packed {logic sync; logic [4:0] ctl; logic oe; logic chk; logic out;} fsu_row_t;
  fsu_row_t rows [8] = '{'{1'b0, 5'h00, 1'b0, 1'b0, 1'b0}, '{1'b0, 5'h18, 1'b1, 1'b1, 1'b1},
    '{1'b0, 5'h08, 1'b1, 1'b1, 1'b0}, '{1'b0, 5'h01, 1'b1, 1'b0, 1'b0},
    '{1'b0, 5'h02, 1'b0, 1'b0, 1'b0}, '{1'b1, 5'h00, 1'b1, 1'b0, 1'b0},
    '{1'b1, 5'h01, 1'b1, 1'b0, 1'b0}, '{1'b1, 5'h0a, 1'b0, 1'b0, 1'b0}};
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic busDo(input logic isWr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !isWr;
    write <= isWr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 16);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      failCount++;
      endSim();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    busDo(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    busDo(1'b0, a, 32'h0);
  endtask
  // hang guard
  initial begin
    #3000000;
    failCount++;
    endSim();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_STATUS);
    check("status reset", q, 32'h0060);
    wr(ADDR_STATUS, 32'hffff);
    rd(ADDR_STATUS);
    check("status ones", q, 32'h0060);
    wr(ADDR_CONTROL, 32'h04);
    rd(ADDR_CONTROL);
    check("control reserved", q, 32'h0);
    rd(4'h9);
    check("unmapped", q, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(ADDR_MODE, {31'h0, rows[i].sync});
      wr(ADDR_CONTROL, {27'h0, rows[i].ctl});
      repeat (8) @(posedge clk);
      check("pin enable", {31'h0, pinOe}, {31'h0, rows[i].oe});
      if (rows[i].chk) check("pin level", {31'h0, pinOut}, {31'h0, rows[i].out});
    end
    $display("test table done");
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_CONTROL, 32'h2);
    repeat (8) @(posedge clk);
    t0 = ticks;
    i_fsu_remote_dev.runClock(5);
    repeat (8) @(posedge clk);
    check("external ticks", ticks - t0, 32'h5);
    $display("test external clock done");
    wr(ADDR_CONTROL, 32'h1);
    repeat (8) @(posedge clk);
    t0 = ticks;
    repeat (80) @(posedge clk);
    check("internal ticks", ticks - t0, {24'h0, 8'h50 / (8'h2 * (BAUD_DIV_RESET + 8'h1))});
    i_fsu_remote_dev.push(1'b1, 1'b0, 8'h11);
    i_fsu_remote_dev.push(1'b0, 1'b1, 8'h22);
    i_fsu_remote_dev.push(1'b1, 1'b1, 8'h33);
    wr(ADDR_STATUS, 32'hff73);
    rd(ADDR_STATUS);
    check("counts three", q & 32'hff8c, 32'h2284);
    wr(ADDR_STATUS, 32'hff7f);
    rd(ADDR_RX_DATA);
    check("rx byte", q, 32'h11);
    rd(ADDR_STATUS);
    check("counts popped", q & 32'hff8c, 32'h1208);
    wr(ADDR_CONTROL, 32'h20);
    rd(ADDR_STATUS);
    check("counts flushed", q & 32'hff8c, 32'h0);
    $display("test error counts done");
    wr(ADDR_IRQ_CLEAR, 32'h7);
    wr(ADDR_IRQ_ENABLE, 32'h4);
    repeat (16) i_fsu_remote_dev.push(1'b1, 1'b1, 8'h44);
    rd(ADDR_STATUS);
    check("counts wrap", q & 32'hff8c, 32'h008c);
    check("irq masked", {31'h0, irq}, 32'h0);
    i_fsu_remote_dev.push(1'b0, 1'b0, 8'h55);
    repeat (3) @(posedge clk);
    check("irq overflow", {31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h4);
    repeat (3) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd(ADDR_IRQ_STATUS);
    check("irq status", q & 32'h7, 32'h3);
    $display("test wrap and irq done");
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    check("reset irq", {31'h0, irq}, 32'h0);
    check("reset pin enable", {31'h0, pinOe}, 32'h0);
    rd(ADDR_STATUS);
    check("status after reset", q, 32'h0060);
    $display("test mid-run reset done");
    endSim();
  end
endmodule // tb
`default_nettype wire

// [rtl/fsu_clock_gen.sv]
// fsu_clock_gen: internal baud divider and serial clock pin steering
`timescale 1ns/1ps
`default_nettype none
module fsu_clock_gen
  import fsu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire logic [1:0] clockSelect,
  input wire logic syncMode,
  input wire logic [7:0] baudDivide,
  input wire logic pinDirection,
  input wire logic pinLevel,
  // external clock rise from the synchroniser
  input wire logic extRise,
  // results
  output logic sampleTick,
  output logic pinOut,
  output logic pinOe
);

  logic [7:0] divCountReg; // baud divider count
  logic intClockReg; // internal serial clock level
  logic intRise; // internal clock rising this cycle
  logic useInternal;

  // source bit low selects the internal divider
  assign useInternal = !clockSelect[1];
  assign intRise = (divCountReg == baudDivide) && !intClockReg;

  // ----------------------------------------
  // internal divider, half period per terminal count
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      divCountReg <= 8'h00;
      intClockReg <= 1'b0;
    end else if (divCountReg == baudDivide) begin
      divCountReg <= 8'h00;
      intClockReg <= !intClockReg;
    end else begin
      divCountReg <= divCountReg + 8'h01;
    end
  end

  // tick source follows the source select
  always_ff @(posedge clk) begin
    if (reset) begin
      sampleTick <= 1'b0;
    end else begin
      sampleTick <= useInternal ? intRise : extRise; // RQ6 RQ8
    end
  end

  // ----------------------------------------
  // pin steering
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else if (!useInternal) begin
      // external source: pin is an input, output select ignored
      pinOut <= 1'b0; // RQ2
      pinOe <= 1'b0; // RQ6 RQ8
    end else if (syncMode || clockSelect == SRC_INT_OUT) begin
      // bit clock out in sync mode, 16x clock out in async mode
      pinOut <= intClockReg; // RQ5 RQ7
      pinOe <= 1'b1;
    end else begin
      // async select 00: pin follows direction and level bits
      pinOut <= pinLevel; // RQ4
      pinOe <= pinDirection;
    end
  end

endmodule // fsu_clock_gen
`default_nettype wire

// [rtl/fsu_edge_sync.sv]
// fsu_edge_sync: three-stage input synchroniser with rise detection
`timescale 1ns/1ps
`default_nettype none
module fsu_edge_sync
  import fsu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // asynchronous input
  input wire logic pinIn,
  // synchronised outputs
  output logic level,
  output logic rise
);

  logic stage1Reg; // metastability catcher
  logic stage2Reg; // first stable sample
  logic stage3Reg; // second stable sample

  // ----------------------------------------
  // sample chain
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1Reg <= 1'b0;
      stage2Reg <= 1'b0;
      stage3Reg <= 1'b0;
      level <= 1'b0;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      // level changes only once stages two and three agree
      if (stage2Reg == stage3Reg) begin
        level <= stage3Reg;
      end
    end
  end

  // rising edge of the filtered level
  always_ff @(posedge clk) begin
    if (reset) begin
      rise <= 1'b0;
    end else begin
      rise <= (stage2Reg == stage3Reg) && stage3Reg && !level;
    end
  end

endmodule // fsu_edge_sync
`default_nettype wire

// [rtl/fsu_pkg.sv]
// fsu_pkg: constants shared by the serial clock select and status block
package fsu_pkg;

  // ----------------------------------------
  // register map (word addresses, one per register)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MODE = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_RX_DATA = 4'h6;
  localparam logic [3:0] ADDR_RX_INJECT = 4'h7;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTL_OUT_SEL = 0;
  localparam int CTL_SRC_SEL = 1;
  localparam int CTL_PIN_DIR = 3;
  localparam int CTL_PIN_LVL = 4;
  localparam int CTL_FIFO_RST = 5;

  // mode register: bit 0 high selects synchronous operation
  localparam int MODE_SYNC = 0;

  // ----------------------------------------
  // status register layout and reset
  // ----------------------------------------
  localparam logic [15:0] STATUS_RESET = 16'h0060;
  localparam logic [7:0] FLAG_RESET = 8'h60;
  localparam int ST_PAR_LO = 12;
  localparam int ST_FRM_LO = 8;
  localparam int ST_ENTRY_FRM = 3;
  localparam int ST_ENTRY_PAR = 2;
  localparam logic [7:0] FLAG_WRITABLE = 8'hf3;

  // ----------------------------------------
  // fifo and baud generator
  // ----------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam logic [7:0] BAUD_DIV_RESET = 8'h03;
  localparam logic [1:0] SRC_INT_NOOUT = 2'h0;
  localparam logic [1:0] SRC_INT_OUT = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // interrupt event bits
  localparam int EV_PAR = 0;
  localparam int EV_FRM = 1;
  localparam int EV_OVF = 2;
  localparam int EV_W = 3;

  // bus handshake state, gray coded along idle -> answer
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } fsu_bus_t;

endpackage

// [rtl/fsu_serial_unit.sv]
// fsu_serial_unit: clock select and receive error status of the fifo serial unit
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RQ1] reserved control bit 2 reads zero
// [RQ2] output select ignored with external source
// [RQ3] software sets mode before clock select
// [RQ4] async 00: internal clock, pin by bits
// [RQ5] async 01: internal clock, 16x out
// [RQ6] async 10: external 16x clock in
// [RQ7] sync 00/01: internal, bit clock out
// [RQ8] sync 10: external bit clock in
// [RQ9] software never writes select 11
// [RQ10] status 16 bits: counts high, flags low
// [RQ11] status always accessible; writing 1 keeps flag
// [RQ12] flag clears on 0 after read as 1
// [RQ13] entry error bits read only
// [RQ14] status resets to 0x0060
// [RQ15] bits 15..12 count parity entries
// [RQ16] sixteen parity entries read as zero
// [RQ17] bits 11..8 count framing entries
// [RQ18] sixteen framing entries read as zero
// [RQ19] counts follow fifo entry, read, reset
module fsu_serial_unit
  import fsu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // receive byte stream from the deserialiser
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxParityFault,
  input wire logic rxFramingFault,
  // serial clock pin
  input wire logic clockPinIn,
  output logic clockPinOut,
  output logic clockPinOe,
  // sampling tick for the serial datapath
  output logic sampleTick,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // receive fault flag position in the low status byte
  localparam int FLAG_RX_FAULT = 7;
  logic [1:0] clockSelReg; // source and output select
  logic pinDirReg; // pin drive when unused
  logic pinLvlReg; // pin level when driven
  logic [7:0] modeReg; // serial mode register
  logic [7:0] baudDivReg; // divider half period
  logic [7:0] flagReg; // low status byte flags
  logic [7:0] flagSeenReg; // flags read as one
  logic [EV_W-1:0] irqStatusReg; // sticky events
  logic [EV_W-1:0] irqEnableReg; // event mask
  fsu_bus_t busStateReg; // handshake state

  // fifo storage
  logic [7:0] fifoData [FIFO_DEPTH];
  logic [FIFO_DEPTH-1:0] fifoPar;
  logic [FIFO_DEPTH-1:0] fifoFrm;
  logic [PTR_W-1:0] wrPtrReg;
  logic [PTR_W-1:0] rdPtrReg;
  logic [PTR_W:0] fillReg; // entries held
  logic [PTR_W-1:0] parCountReg; // parity entries, mod 16
  logic [PTR_W-1:0] frmCountReg; // framing entries, mod 16

  // ----------------------------------------
  // decoded strobes
  // ----------------------------------------
  logic busAccept;
  logic busRequest;
  logic wrCtl;
  logic wrStatus;
  logic rdStatus;
  logic rdData;
  logic fifoReset;
  logic fifoPush;
  logic fifoPop;
  logic pushPar;
  logic pushFrm;
  logic popPar;
  logic popFrm;
  logic fifoFull;
  logic fifoEmpty;
  logic [15:0] statusWord;
  logic extLevel;
  logic extRise;

  // answers land one cycle after the request is seen
  assign busAccept = (busStateReg == BUS_ANSWER);
  // reads act with the data capture, so flags marked as seen and a
  // popped byte always match what the bus returns
  assign busRequest = (busStateReg == BUS_IDLE) && read;
  assign wrCtl = busAccept && write && address == ADDR_CONTROL;
  assign wrStatus = busAccept && write && address == ADDR_STATUS;
  assign rdStatus = busRequest && address == ADDR_STATUS;
  assign rdData = busRequest && address == ADDR_RX_DATA;
  assign fifoReset = wrCtl && writedata[CTL_FIFO_RST];
  assign fifoFull = fillReg[PTR_W];
  assign fifoEmpty = (fillReg == '0);
  assign fifoPush = rxValid && !fifoFull && !fifoReset;
  assign fifoPop = rdData && !fifoEmpty && !fifoReset;
  assign pushPar = fifoPush && rxParityFault;
  assign pushFrm = fifoPush && rxFramingFault;
  assign popPar = fifoPop && fifoPar[rdPtrReg];
  assign popFrm = fifoPop && fifoFrm[rdPtrReg];

  // count step: up on erroneous entry, down on its removal
  // entry and removal in one cycle leave the count alone
  function automatic logic [PTR_W-1:0] stepCount(input logic [PTR_W-1:0] cnt,
                                                  input logic up, input logic down);
    logic [PTR_W-1:0] res;
    res = cnt;
    if (up && !down) begin
      res = cnt + 4'h1;
    end else if (down && !up) begin
      res = cnt - 4'h1;
    end
    return res;
  endfunction

  // ----------------------------------------
  // status word assembly
  // ----------------------------------------
  always_comb begin
    statusWord = '0;
    statusWord[ST_PAR_LO +: PTR_W] = parCountReg; // RQ15 RQ16
    statusWord[ST_FRM_LO +: PTR_W] = frmCountReg; // RQ17 RQ18
    statusWord[7:0] = flagReg; // RQ10
    // entry bits reflect the head entry and are not stored flags
    statusWord[ST_ENTRY_FRM] = !fifoEmpty && fifoFrm[rdPtrReg]; // RQ13
    statusWord[ST_ENTRY_PAR] = !fifoEmpty && fifoPar[rdPtrReg]; // RQ13
  end

  // ----------------------------------------
  // bus handshake: one wait cycle per access
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      busStateReg <= BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      case (busStateReg)
        BUS_IDLE: begin
          // a request drops waitrequest for exactly one cycle
          if (read || write) begin
            busStateReg <= BUS_ANSWER;
            waitrequest <= 1'b0;
          end
        end
        BUS_ANSWER: begin
          busStateReg <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          busStateReg <= BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read data, registered with the request (always permitted)
  always_ff @(posedge clk) begin
    if (reset) begin
      readdata <= '0;
    end else if (busRequest) begin
      case (address)
        // reserved bit 2 always zero
        ADDR_CONTROL: readdata <= {26'h0, 1'b0, pinLvlReg, pinDirReg, 1'b0,
                                   clockSelReg}; // RQ1
        ADDR_STATUS: readdata <= {16'h0, statusWord}; // RQ11
        ADDR_MODE: readdata <= {24'h0, modeReg};
        ADDR_IRQ_STATUS: readdata <= {29'h0, irqStatusReg};
        ADDR_IRQ_ENABLE: readdata <= {29'h0, irqEnableReg};
        ADDR_RX_DATA: readdata <= {24'h0, fifoEmpty ? 8'h00 : fifoData[rdPtrReg]};
        ADDR_RX_INJECT: readdata <= {24'h0, baudDivReg};
        default: readdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // control, mode and divider registers
  // ----------------------------------------
  // control fields; reserved bit 2 is never stored
  always_ff @(posedge clk) begin
    if (reset) begin
      clockSelReg <= SRC_INT_NOOUT;
      pinDirReg <= 1'b0;
      pinLvlReg <= 1'b0;
    end else if (wrCtl) begin
      clockSelReg <= writedata[CTL_SRC_SEL -: 2];
      pinDirReg <= writedata[CTL_PIN_DIR];
      pinLvlReg <= writedata[CTL_PIN_LVL];
    end
  end

  // mode and divider words, written whole
  always_ff @(posedge clk) begin
    if (reset) begin
      modeReg <= 8'h00;
      baudDivReg <= BAUD_DIV_RESET;
    end else if (busAccept && write) begin
      if (address == ADDR_MODE) begin
        modeReg <= writedata[7:0];
      end
      if (address == ADDR_RX_INJECT) begin
        baudDivReg <= writedata[7:0];
      end
    end
  end

  // ----------------------------------------
  // status flags: read-then-write-zero clear
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      flagReg <= FLAG_RESET; // RQ14
      flagSeenReg <= 8'h00;
    end else begin
      // receive fault flag set by any erroneous entry; set beats clear
      for (int i = 0; i < 8; i++) begin
        if (i == FLAG_RX_FAULT && (pushPar || pushFrm)) begin
          flagReg[i] <= 1'b1;
        end else if (wrStatus && FLAG_WRITABLE[i] && !writedata[i] && flagSeenReg[i]) begin
          flagReg[i] <= 1'b0; // RQ12
        end
        // written ones leave flags alone
      end
      if (rdStatus) begin
        flagSeenReg <= flagReg & FLAG_WRITABLE; // RQ12
      end else if (wrStatus) begin
        flagSeenReg <= flagSeenReg & writedata[7:0]; // RQ11
      end
    end
  end

  // ----------------------------------------
  // receive fifo with error tallies
  // ----------------------------------------
  // data array, written on every accepted push
  always_ff @(posedge clk) begin
    if (fifoPush) begin
      fifoData[wrPtrReg] <= rxByte;
    end
  end

  // pointers, fill level and tallies; a fifo reset clears them all
  always_ff @(posedge clk) begin
    if (reset || fifoReset) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      fillReg <= '0;
      fifoPar <= '0;
      fifoFrm <= '0;
      parCountReg <= '0; // RQ19
      frmCountReg <= '0; // RQ19
    end else begin
      if (fifoPush) begin
        wrPtrReg <= wrPtrReg + 4'h1;
        fifoPar[wrPtrReg] <= rxParityFault;
        fifoFrm[wrPtrReg] <= rxFramingFault;
      end
      if (fifoPop) begin
        rdPtrReg <= rdPtrReg + 4'h1;
      end
      fillReg <= fillReg + {4'h0, fifoPush} - {4'h0, fifoPop};
      // four-bit counts wrap, so a full erroneous fifo reads zero
      parCountReg <= stepCount(parCountReg, pushPar, popPar); // RQ15 RQ16 RQ19
      frmCountReg <= stepCount(frmCountReg, pushFrm, popFrm); // RQ17 RQ18 RQ19
    end
  end

  // ----------------------------------------
  // interrupts: sticky events, write-one clear
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      irqStatusReg <= '0;
      irqEnableReg <= '0;
    end else begin
      // set wins over clear in the same cycle
      irqStatusReg <= (irqStatusReg & ~((busAccept && write && address == ADDR_IRQ_CLEAR)
                      ? writedata[EV_W-1:0] : 3'h0))
                      | {rxValid && fifoFull, pushFrm, pushPar};
      if (busAccept && write && address == ADDR_IRQ_ENABLE) begin
        irqEnableReg <= writedata[EV_W-1:0];
      end
    end
  end

  // level interrupt, one cycle behind the sticky status
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatusReg & irqEnableReg);
    end
  end

  // ----------------------------------------
  // serial clock pin
  // ----------------------------------------
  // pin passes three flops before its edges are used
  fsu_edge_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pinIn(clockPinIn),
    .level(extLevel),
    .rise(extRise)
  );

  // level is kept for the datapath; only edges matter here
  logic unusedLevel;
  assign unusedLevel = extLevel;

  // internal divider and pin steering
  fsu_clock_gen u_clk (
    .clk(clk),
    .reset(reset),
    .clockSelect(clockSelReg), // RQ3 RQ9
    .syncMode(modeReg[MODE_SYNC]),
    .baudDivide(baudDivReg),
    .pinDirection(pinDirReg),
    .pinLevel(pinLvlReg),
    .extRise(extRise),
    .sampleTick(sampleTick),
    .pinOut(clockPinOut),
    .pinOe(clockPinOe)
  );

endmodule // fsu_serial_unit
`default_nettype wire
